// ---- core/bss_boot_sequencer.v ----
`timescale 1ns/1ns
`default_nettype none
`include "bss_defines.vh"
module bss_boot_sequencer #(
  parameter integer SETTLE_CYC = `BSS_SETTLE_CYC,
  parameter integer PROBE_CYC = `BSS_PROBE_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Start causes
  input wire cold_power_up,
  input wire hw_reset,
  input wire wake_up,
  // Analogue indications (asynchronous)
  input wire boost_supply_ok,
  input wire ref_settled,
  input wire core_ldo_settled,
  input wire mem_ldo_settled,
  input wire xtal_settled,
  // Software controls
  input wire timeout_disable,
  input wire copy_enable,
  input wire nwords_load,
  input wire [14:0] nwords_wdata,
  input wire patch_done,
  input wire host_reply,
  // Memory read port
  output reg mem_rd_q,
  output reg [14:0] mem_addr_q,
  input wire mem_rvalid,
  input wire [31:0] mem_rdata,
  // System RAM write port
  output reg ram_wr_q,
  output reg [14:0] ram_addr_q,
  output reg [31:0] ram_wdata_q,
  // Power controls
  output reg dcdc_en_q,
  output reg dcdc_boost_q,
  output reg ref_en_q,
  output reg core_ldo_en_q,
  output reg mem_ldo_en_q,
  output reg fast_crystal_oscillator_en_q,
  // Status and decoded header
  output reg cold_start_q,
  output reg [3:0] state_q,
  output reg cpu_run_q,
  output reg [1:0] boot_mode_q,
  output reg debug_port_on_pins_q,
  output reg [2:0] sig_alg_q,
  output reg slow_rc_oscillator_sel_q,
  output reg calibrated_q,
  output reg [5:0] trim_valid_q,
  output reg [14:0] mirror_word_count_q,
  output reg [31:0] quad_trim_q,
  output reg [31:0] trim_crc_q,
  output reg [15:0] sbl_len_q,
  output reg [15:0] sbl_ofs_q,
  output reg [63:0] link_addr_q,
  output reg address_zero_remap_q,
  output reg soft_reset_q,
  // Host search
  output wire probe_active,
  output wire [3:0] probe_step,
  output wire [7:0] probe_char,
  output wire probe_send,
  output wire [1:0] probe_if_kind,
  output wire [2:0] probe_clk_pin,
  output wire [2:0] probe_sel_pin,
  output wire [2:0] probe_din_pin,
  output wire [2:0] probe_dout_pin
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_BOOST = 4'h1;
  localparam [3:0] S_LDO = 4'h2;
  localparam [3:0] S_XTAL = 4'h3;
  localparam [3:0] S_BRANCH = 4'h4;
  localparam [3:0] S_MIRROR = 4'h5;
  localparam [3:0] S_HDR = 4'h6;
  localparam [3:0] S_DECIDE = 4'h7;
  localparam [3:0] S_PATCH = 4'h9;
  localparam [3:0] S_REMAP = 4'ha;
  localparam [3:0] S_DEVEL = 4'hb;
  localparam [3:0] S_RUN = 4'hc;
  localparam [3:0] S_NHDR = 4'hd;

  // Two-stage synchronisers
  reg [5:0] ind_s1_q;
  reg [5:0] ind_q;
  always @(posedge sys_clk) begin
    ind_s1_q <= {hw_reset, boost_supply_ok, ref_settled, core_ldo_settled,
                 mem_ldo_settled, xtal_settled};
    ind_q <= ind_s1_q;
  end
  wire sy_boost = ind_q[4];
  wire sy_ldo = ind_q[3] & ind_q[2] & ind_q[1];
  wire sy_xtal = ind_q[0];

  reg [31:0] tmo_q;
  reg [3:0] hdr_idx_q;
  reg [14:0] cpy_q;
  reg fw_path_q;
  reg [31:0] flag1_q;
  reg [31:0] flag2_q;
  reg probe_start_q;
  reg rd_pend_q;

  // Settle wait: indication or timeout, unless disabled
  wire tmo_hit = !timeout_disable && (tmo_q >= SETTLE_CYC - 1);

  // Header fetch order
  reg [14:0] hdr_adr;
  always @* begin
    case (hdr_idx_q)
      4'h0: hdr_adr = `BSS_ADR_FLAG1;
      4'h1: hdr_adr = `BSS_ADR_FLAG2;
      4'h2: hdr_adr = `BSS_ADR_NWORDS;
      4'h3: hdr_adr = `BSS_ADR_DBG_FLAG;
      4'h4: hdr_adr = `BSS_ADR_SIG_SEL;
      4'h5: hdr_adr = `BSS_ADR_LINK_ADR;
      4'h6: hdr_adr = `BSS_ADR_LINK_ADR + 15'h4;
      4'h7: hdr_adr = `BSS_ADR_IQ_TRIM;
      4'h8: hdr_adr = `BSS_ADR_TRIM_CRC;
      4'h9: hdr_adr = `BSS_ADR_SBL_OFS;
      4'ha: hdr_adr = `BSS_ADR_CAL_FLAG;
      default: hdr_adr = `BSS_ADR_SLP_CLK;
    endcase
  end

  // Byte-replicated flag decode
  function [2:0] sig_dec;
    input [31:0] w;
    begin
      if (w == {4{`BSS_BYTE_00}}) sig_dec = `BSS_SIG_NONE;
      else if (w == {4{`BSS_BYTE_AA}}) sig_dec = `BSS_SIG_MD5;
      else if (w == {4{`BSS_BYTE_55}}) sig_dec = `BSS_SIG_SHA1;
      else if (w == {4{`BSS_BYTE_FF}}) sig_dec = `BSS_SIG_CRC32;
      else sig_dec = `BSS_SIG_BAD;
    end
  endfunction

  always @(posedge sys_clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      tmo_q <= 32'h0;
      hdr_idx_q <= 4'h0;
      cpy_q <= 15'h0;
      fw_path_q <= 1'b0;
      flag1_q <= 32'h0;
      flag2_q <= 32'h0;
      probe_start_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_addr_q <= 15'h0;
      rd_pend_q <= 1'b0;
      ram_wr_q <= 1'b0;
      ram_addr_q <= 15'h0;
      ram_wdata_q <= 32'h0;
      dcdc_en_q <= 1'b0;
      dcdc_boost_q <= 1'b0;
      ref_en_q <= 1'b0;
      core_ldo_en_q <= 1'b0;
      mem_ldo_en_q <= 1'b0;
      fast_crystal_oscillator_en_q <= 1'b0;
      cold_start_q <= 1'b0;
      cpu_run_q <= 1'b0;
      boot_mode_q <= `BSS_MODE_DEVEL;
      debug_port_on_pins_q <= 1'b1;
      sig_alg_q <= `BSS_SIG_NONE;
      slow_rc_oscillator_sel_q <= 1'b0;
      calibrated_q <= 1'b0;
      trim_valid_q <= 6'h0;
      mirror_word_count_q <= 15'h0;
      quad_trim_q <= 32'h0;
      trim_crc_q <= 32'h0;
      sbl_len_q <= 16'h0;
      sbl_ofs_q <= 16'h0;
      link_addr_q <= 64'h0;
      address_zero_remap_q <= 1'b0;
      soft_reset_q <= 1'b0;
    end else begin
      mem_rd_q <= 1'b0;
      ram_wr_q <= 1'b0;
      probe_start_q <= 1'b0;
      soft_reset_q <= 1'b0;
      if (mem_rvalid) rd_pend_q <= 1'b0;
      if (cold_power_up) cold_start_q <= 1'b1;
      // Count survives sleep; a software load or header word 0x7FF8 changes it
      if (nwords_load) mirror_word_count_q <= nwords_wdata;
      case (state_q)
        S_IDLE: begin
          if (cold_power_up || ind_q[5] || wake_up) begin
            state_q <= S_BOOST;
            cpu_run_q <= 1'b0;
            if (ind_q[5]) cold_start_q <= 1'b1;
          end
        end
        S_BOOST: begin
          tmo_q <= 32'h0;
          if (sy_boost) begin
            dcdc_en_q <= 1'b1;
            dcdc_boost_q <= 1'b1;
          end
          ref_en_q <= 1'b1;
          core_ldo_en_q <= 1'b1;
          mem_ldo_en_q <= 1'b1;
          state_q <= S_LDO;
        end
        S_LDO: begin
          tmo_q <= tmo_q + 32'h1;
          if (sy_ldo || tmo_hit) begin
            tmo_q <= 32'h0;
            fast_crystal_oscillator_en_q <= 1'b1;
            dcdc_boost_q <= sy_boost;
            state_q <= S_XTAL;
          end
        end
        S_XTAL: begin
          tmo_q <= tmo_q + 32'h1;
          if (sy_xtal || tmo_hit) begin
            tmo_q <= 32'h0;
            state_q <= S_BRANCH;
          end
        end
        S_BRANCH: begin
          cpy_q <= 15'h0;
          hdr_idx_q <= 4'h0;
          if (cold_start_q) begin
            cold_start_q <= cold_power_up;
            cpu_run_q <= 1'b1;
            state_q <= S_HDR;
          end else if (copy_enable && mirror_word_count_q != 15'h0) begin
            state_q <= S_MIRROR;
          end else begin
            state_q <= S_RUN;
          end
        end
        S_MIRROR: begin
          // One word in flight at a time: simple, trades speed for size
          if (mem_rvalid) begin
            ram_wr_q <= 1'b1;
            ram_addr_q <= {cpy_q[12:0], 2'b00};
            ram_wdata_q <= mem_rdata;
            cpy_q <= cpy_q + 15'h1;
            if (cpy_q + 15'h1 == mirror_word_count_q) state_q <= S_RUN;
          end else if (!rd_pend_q) begin
            mem_rd_q <= 1'b1;
            rd_pend_q <= 1'b1;
            mem_addr_q <= {cpy_q[12:0], 2'b00};
          end
        end
        S_HDR: begin
          if (mem_rvalid) begin
            case (hdr_idx_q)
              4'h0: flag1_q <= mem_rdata;
              4'h1: flag2_q <= mem_rdata;
              4'h2: mirror_word_count_q <= mem_rdata[14:0];
              4'h3: debug_port_on_pins_q <= (mem_rdata != {4{`BSS_BYTE_AA}});
              4'h4: sig_alg_q <= sig_dec(mem_rdata);
              4'h5: link_addr_q[31:0] <= mem_rdata;
              4'h6: link_addr_q[63:32] <= mem_rdata;
              4'h7: quad_trim_q <= mem_rdata;
              4'h8: trim_crc_q <= mem_rdata;
              4'h9: begin
                sbl_ofs_q <= mem_rdata[15:0];
                sbl_len_q <= mem_rdata[31:16];
              end
              4'ha: begin
                calibrated_q <= (mem_rdata[31:16] == `BSS_CAL_DONE);
                trim_valid_q <= mem_rdata[5:0];
              end
              default: slow_rc_oscillator_sel_q <= (mem_rdata == {4{`BSS_BYTE_AA}});
            endcase
            if (hdr_idx_q == 4'hb) begin
              state_q <= S_DECIDE;
              hdr_idx_q <= 4'h0;
            end else begin
              hdr_idx_q <= hdr_idx_q + 4'h1;
            end
          end else if (!rd_pend_q) begin
            mem_rd_q <= 1'b1;
            rd_pend_q <= 1'b1;
            mem_addr_q <= hdr_adr;
          end
        end
        S_DECIDE: begin
          if (flag1_q == `BSS_FLAG1_VAL && flag2_q == `BSS_FLAG2_VAL) begin
            boot_mode_q <= `BSS_MODE_NORMAL;
            fw_path_q <= 1'b1;
            hdr_idx_q <= 4'h2;
            state_q <= S_NHDR;
          end else if (flag1_q == 32'h0 && flag2_q == 32'h0) begin
            boot_mode_q <= `BSS_MODE_DEVEL;
            probe_start_q <= 1'b1;
            state_q <= S_DEVEL;
          end else begin
            boot_mode_q <= `BSS_MODE_FAULTY;
            state_q <= S_RUN;
          end
        end
        S_NHDR: begin
          // Header settings go to registers before the application copy
          fw_path_q <= 1'b0;
          hdr_idx_q <= 4'h2;
          state_q <= S_HDR;
          boot_mode_q <= `BSS_MODE_NORMAL;
        end
        S_PATCH: begin
          if (patch_done) state_q <= S_REMAP;
        end
        S_REMAP: begin
          address_zero_remap_q <= 1'b1;
          soft_reset_q <= 1'b1;
          state_q <= S_RUN;
        end
        S_DEVEL: begin
          if (!probe_active && !probe_start_q) state_q <= S_RUN;
        end
        S_RUN: begin
          cpu_run_q <= 1'b1;
          if (wake_up || cold_power_up || ind_q[5]) state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
      // Normal mode: mirror, then patch
      if (state_q == S_HDR && mem_rvalid && hdr_idx_q == 4'hb &&
          boot_mode_q == `BSS_MODE_NORMAL && flag1_q == `BSS_FLAG1_VAL) begin
        state_q <= S_MIRROR;
        fw_path_q <= 1'b1;
        cpy_q <= 15'h0;
      end
      if (state_q == S_MIRROR && fw_path_q && mem_rvalid &&
          cpy_q + 15'h1 == mirror_word_count_q) begin
        state_q <= S_PATCH;
        fw_path_q <= 1'b0;
      end
    end
  end

  bss_probe_seq #(.TIMEOUT_CYC(PROBE_CYC)) u_probe (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(probe_start_q),
    .host_reply(host_reply),
    .active_q(probe_active),
    .found_q(),
    .exhausted_q(),
    .step_q(probe_step),
    .probe_char_q(probe_char),
    .probe_send_q(probe_send),
    .if_kind(probe_if_kind),
    .clk_pin(probe_clk_pin),
    .sel_pin(probe_sel_pin),
    .din_pin(probe_din_pin),
    .dout_pin(probe_dout_pin)
  );
endmodule // bss_boot_sequencer
`default_nettype wire

// ---- core/bss_probe_seq.v ----
`timescale 1ns/1ns
`default_nettype none
`include "bss_defines.vh"
// Download-host search with per-step pin map
module bss_probe_seq #(
  parameter integer TIMEOUT_CYC = `BSS_PROBE_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Control
  input wire start,
  input wire host_reply,
  // Status
  output reg active_q,
  output reg found_q,
  output reg exhausted_q,
  output reg [3:0] step_q,
  output reg [7:0] probe_char_q,
  output reg probe_send_q,
  // Pin map: interface kind 0 SPI master,1 UART,2 SPI slave,3 I2C
  output reg [1:0] if_kind,
  output reg [2:0] clk_pin,
  output reg [2:0] sel_pin,
  output reg [2:0] din_pin,
  output reg [2:0] dout_pin
);
  reg [31:0] tmo_q;
  reg [1:0] pair;
  always @* begin
    pair = 2'h0;
    if_kind = 2'h0;
    clk_pin = 3'h0;
    sel_pin = 3'h0;
    din_pin = 3'h0;
    dout_pin = 3'h0;
    case (step_q)
      4'h0: begin
        clk_pin = 3'h0; sel_pin = 3'h3; din_pin = 3'h6; dout_pin = 3'h5;
      end
      4'h1: begin
        clk_pin = 3'h0; sel_pin = 3'h1; din_pin = 3'h2; dout_pin = 3'h3;
      end
      4'h2, 4'h3, 4'h4, 4'h5: begin
        if_kind = 2'h1;
        pair = step_q[1:0] - 2'h2;
        clk_pin = {pair, 1'b0};
        din_pin = {pair, 1'b1};
        dout_pin = {pair, 1'b0};
      end
      4'h6: begin
        if_kind = 2'h2;
        clk_pin = 3'h0; sel_pin = 3'h3; din_pin = 3'h6; dout_pin = 3'h5;
      end
      default: begin
        if_kind = 2'h3;
        pair = step_q[1:0] - 2'h3;
        clk_pin = {pair, 1'b0};
        din_pin = {pair, 1'b1};
        dout_pin = {pair, 1'b1};
      end
    endcase
  end
  always @(posedge sys_clk) begin
    if (srst) begin
      active_q <= 1'b0;
      found_q <= 1'b0;
      exhausted_q <= 1'b0;
      step_q <= 4'h0;
      probe_char_q <= 8'h00;
      probe_send_q <= 1'b0;
      tmo_q <= 32'h0;
    end else begin
      probe_send_q <= 1'b0;
      if (start && !active_q) begin
        active_q <= 1'b1;
        step_q <= 4'h0;
        tmo_q <= 32'h0;
        probe_char_q <= `BSS_PROBE_CHAR;
        probe_send_q <= 1'b1;
      end else if (active_q) begin
        if (host_reply) begin
          active_q <= 1'b0;
          found_q <= 1'b1;
        end else if (tmo_q >= TIMEOUT_CYC - 1) begin
          tmo_q <= 32'h0;
          if (step_q == `BSS_PROBE_LAST) begin
            active_q <= 1'b0;
            exhausted_q <= 1'b1;
          end else begin
            step_q <= step_q + 4'h1;
            probe_send_q <= 1'b1;
          end
        end else begin
          tmo_q <= tmo_q + 32'h1;
        end
      end
    end
  end
endmodule // bss_probe_seq
`default_nettype wire

// ---- include/bss_defines.vh ----
// Summary of operation
// - Flag two at 0x7F04 must read 0xA5A51234
// - Flag one at 0x7F00 must read 0x1234A5A5
// - Loader length at 0x7F12, offset at 0x7F10
// - Trim checksum 0x7F0C, quadrature trim 0x7F08
// - Word 0x7FFC routes debug port; default routed
// - Word 0x7FF8 holds mirror word count
// - Link address: two words from 0x7FD4
// - Word 0x7FD0 selects payload signature algorithm
// - Stages run power, mirror, then firmware
// - Cold-start flip-flop set at power-up
// - Firmware runs only after cold start/reset
// - Boost check, regulators, crystal, converter recheck
// - Settle polls time out unless disabled
// - Wake-up copy by hardware when enabled
// - Word count loaded once, kept through sleep
// - Both flags normal; zeros development; else faulty
// - Development probes steps 0 to 10
// - UART/I2C use pin pairs even/odd
// - SPI master/slave pin assignment per step
// - Each probe sends character, times out onward
// - Normal: settings, mirror, patch, remap, reset
// - Calibration upper 0xA5A5, six trim valid bits
// - Debug flag 0x00 enabled, 0xAA disabled
// - Signature 0x00 none,0xAA,0x55,0xFF
// - Sleep clock 0x00 crystal, 0xAA RC
`ifndef BSS_DEFINES_VH
`define BSS_DEFINES_VH
`define BSS_ADR_FLAG2 15'h7f04
`define BSS_ADR_FLAG1 15'h7f00
`define BSS_ADR_SBL_LEN 15'h7f12
`define BSS_ADR_SBL_OFS 15'h7f10
`define BSS_ADR_TRIM_CRC 15'h7f0c
`define BSS_ADR_IQ_TRIM 15'h7f08
`define BSS_ADR_DBG_FLAG 15'h7ffc
`define BSS_ADR_NWORDS 15'h7ff8
`define BSS_ADR_LINK_ADR 15'h7fd4
`define BSS_ADR_SIG_SEL 15'h7fd0
`define BSS_ADR_CAL_FLAG 15'h7f78
`define BSS_ADR_SLP_CLK 15'h7f74
`define BSS_FLAG2_VAL 32'ha5a51234
`define BSS_FLAG1_VAL 32'h1234a5a5
`define BSS_CAL_DONE 16'ha5a5
`define BSS_BYTE_00 8'h00
`define BSS_BYTE_AA 8'haa
`define BSS_BYTE_55 8'h55
`define BSS_BYTE_FF 8'hff
`define BSS_SIG_NONE 3'h0
`define BSS_SIG_MD5 3'h1
`define BSS_SIG_SHA1 3'h2
`define BSS_SIG_CRC32 3'h3
`define BSS_SIG_BAD 3'h4
`define BSS_MODE_NORMAL 2'h0
`define BSS_MODE_DEVEL 2'h1
`define BSS_MODE_FAULTY 2'h2
`define BSS_PROBE_LAST 4'ha
`define BSS_SETTLE_US 100
`define BSS_SETTLE_CYC ((`BSS_SETTLE_US * 1000) / 10)
`define BSS_PROBE_US 20
`define BSS_PROBE_CYC ((`BSS_PROBE_US * 1000) / 10)
`define BSS_PROBE_CHAR 8'h01
`endif

// ---- verification/bss_boot_sequencer_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module bss_boot_sequencer_bench;
  localparam int SC = 8;
  localparam int PC = 8;
  logic sys_clk = 1'b0;
  logic srst, cold_power_up, hw_reset, wake_up, boost_supply_ok, slow, host_reply;
  logic ref_settled, core_ldo_settled, mem_ldo_settled, xtal_settled;
  logic timeout_disable, copy_enable, nwords_load, patch_done;
  logic [14:0] nwords_wdata, mem_addr_q, ram_addr_q, mirror_word_count_q;
  logic mem_rd_q, mem_rvalid, ram_wr_q, dcdc_en_q, dcdc_boost_q, ref_en_q, core_ldo_en_q;
  logic mem_ldo_en_q, fast_crystal_oscillator_en_q, cold_start_q, cpu_run_q, calibrated_q;
  logic debug_port_on_pins_q, slow_rc_oscillator_sel_q, address_zero_remap_q, soft_reset_q;
  logic probe_active, probe_send;
  logic [31:0] mem_rdata, ram_wdata_q, quad_trim_q, trim_crc_q;
  logic [3:0] state_q, probe_step, stl;
  logic [1:0] boot_mode_q, probe_if_kind;
  logic [2:0] sig_alg_q, probe_clk_pin, probe_sel_pin, probe_din_pin, probe_dout_pin;
  logic [5:0] trim_valid_q;
  logic [15:0] sbl_len_q, sbl_ofs_q;
  logic [63:0] link_addr_q;
  logic [7:0] probe_char;
  logic [3:0] plog [0:15];
  logic [3:0] evt;
  int mismatches = 0;
  int check_count = 0;
  int wr_n, rs_n, pr_n, want;
  assign evt = {wr_n >= want, pr_n > 10, rs_n > 0, cpu_run_q === 1'b1 && state_q === 4'hc};
  assign {ref_settled, core_ldo_settled, mem_ldo_settled, xtal_settled} = stl;
  always #5 sys_clk = ~sys_clk;
  bss_boot_sequencer #(.SETTLE_CYC(SC), .PROBE_CYC(PC)) DUT (.*);
  bss_otp_model u_mem (.*);
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (ram_wr_q === 1'b1) wr_n <= wr_n + 1;
    if (soft_reset_q === 1'b1) rs_n <= rs_n + 1;
    if (probe_send === 1'b1) begin
      if (pr_n < 16) plog[pr_n] <= probe_step;
      pr_n <= pr_n + 1;
      chk(probe_char === 8'h01, "probe character");
    end
  end
  task automatic rst;
    srst = 1'b1;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // Start cause held until the sequencer is past idle
  task automatic go(input int c);
    int n;
    n = 0;
    {hw_reset, wake_up, cold_power_up} = 3'(1 << c);
    while ((state_q === 4'h0 || state_q === 4'hc) && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    {hw_reset, wake_up, cold_power_up} = 3'h0;
    {wr_n, rs_n, pr_n} = 96'h0;
  endtask
  task automatic await(input int b, input int lim);
    int n;
    n = 0;
    while (evt[b] !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk(evt[b] === 1'b1, "completion wait");
  endtask
  task automatic ld(input logic [14:0] n);
    nwords_wdata = n;
    nwords_load = 1'b1;
    @(negedge sys_clk);
    nwords_load = 1'b0;
  endtask
  task automatic fill(input logic z);
    for (int k = 0; k < 8192; k++) u_mem.mem[k] = z ? 32'h0 : 32'(k * 3 + 1);
  endtask
  task automatic pk(input logic [14:0] a, input logic [31:0] d);
    u_mem.mem[a[14:2]] = d;
  endtask
  task automatic hdr(input logic [31:0] f2, input logic [7:0] sig, input logic [7:0] oth);
    pk(15'h7f00, 32'h1234a5a5);
    pk(15'h7f04, f2);
    pk(15'h7f08, 32'h13572468);
    pk(15'h7f0c, 32'h9abcdef0);
    pk(15'h7f10, 32'h00400100);
    pk(15'h7f74, {4{oth}});
    pk(15'h7f78, 32'ha5a5002a);
    pk(15'h7fd0, {4{sig}});
    pk(15'h7fd4, 32'h11223344);
    pk(15'h7fd8, 32'h00005566);
    pk(15'h7ff8, 32'h4);
    pk(15'h7ffc, {4{oth}});
  endtask
  task automatic t_normal;
    logic [7:0] codes [0:3];
    codes = '{8'h00, 8'haa, 8'h55, 8'hff};
    for (int i = 0; i < 4; i++) begin
      rst;
      fill(1'b0);
      hdr(32'ha5a51234, codes[i], i[0] ? 8'haa : 8'h00);
      patch_done = 1'b0;
      want = 4;
      go(0);
      await(3, 1500);
      repeat (SC) @(negedge sys_clk);
      chk(address_zero_remap_q === 1'b0 && rs_n == 0, "remap before patch");
      patch_done = 1'b1;
      await(1, 200);
      chk(boot_mode_q === 2'h0 && pr_n == 0, "normal mode");
      chk(wr_n == 4 && mirror_word_count_q === 15'h4, "mirror count");
      chk(address_zero_remap_q === 1'b1 && rs_n == 1, "remap and reset");
      chk(cold_start_q === 1'b0 && cpu_run_q === 1'b1, "cold start consumed");
      chk(sig_alg_q === 3'(i), "signature selector");
      chk(debug_port_on_pins_q === !i[0], "debug pins flag");
      chk(slow_rc_oscillator_sel_q === i[0], "sleep clock flag");
      chk({calibrated_q, trim_valid_q} === 7'h6a, "calibration");
      chk(link_addr_q === 64'h0000556611223344, "link address");
      chk({quad_trim_q, trim_crc_q} === 64'h135724689abcdef0, "trims");
      chk({sbl_len_q, sbl_ofs_q} === 32'h00400100, "loader fields");
      chk({ref_en_q, core_ldo_en_q, mem_ldo_en_q} === 3'h7, "ldo");
    end
  endtask
  // Wake-up: slow memory, boost, no settle indications
  task automatic t_wake;
    stl = 4'h0;
    boost_supply_ok = 1'b1;
    slow = 1'b1;
    ld(15'h3);
    for (int c = 1; c >= 0; c--) begin
      copy_enable = c[0];
      want = 3 * c;
      go(1);
      await(3, 800);
      await(0, 800);
      chk(wr_n == 3 * c && rs_n == 0 && pr_n == 0, "wake-up copy");
      chk({dcdc_en_q, dcdc_boost_q} === 2'h3, "boost converter");
      chk(mirror_word_count_q === 15'h3, "count kept");
    end
    boost_supply_ok = 1'b0;
    slow = 1'b0;
  endtask
  task automatic t_hold;
    rst;
    timeout_disable = 1'b1;
    copy_enable = 1'b1;
    ld(15'h2);
    want = 2;
    go(1);
    repeat (10 * SC) @(negedge sys_clk);
    chk(cpu_run_q === 1'b0 && wr_n == 0, "settle wait held");
    stl = 4'hf;
    await(0, 400);
    chk(wr_n == 2, "copy after settle");
    timeout_disable = 1'b0;
  endtask
  task automatic t_faulty;
    rst;
    fill(1'b0);
    hdr(32'ha5a51235, 8'h00, 8'h00);
    go(2);
    await(0, 1500);
    chk(boot_mode_q === 2'h2 && pr_n == 0, "faulty memory");
  endtask
  task automatic t_devel;
    int n;
    rst;
    fill(1'b1);
    go(0);
    await(2, 3000);
    chk(boot_mode_q === 2'h1, "development mode");
    for (int k = 0; k < 11; k++) chk(plog[k] === 4'(k), "probe order");
    rst;
    go(0);
    n = 0;
    while ({probe_active, probe_step} !== 5'h13 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    host_reply = 1'b1;
    repeat (4 * PC) @(negedge sys_clk);
    chk(probe_step === 4'h3 && pr_n == 4, "reply stops search");
    host_reply = 1'b0;
  endtask
  initial begin
    {srst, cold_power_up, hw_reset, wake_up, boost_supply_ok, slow, host_reply} = 7'h40;
    stl = 4'hf;
    {timeout_disable, copy_enable, nwords_load, patch_done} = 4'h0;
    nwords_wdata = 15'h0;
    want = 0;
    rst;
    chk({debug_port_on_pins_q, boot_mode_q} === 3'h5, "reset state");
    chk({cpu_run_q, state_q} === 5'h0, "idle after reset");
    t_normal;
    t_wake;
    t_hold;
    t_faulty;
    t_devel;
    give_verdict;
  end
  // Watchdog: about fifty times the expected run
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    give_verdict;
  end
endmodule // bss_boot_sequencer_bench
`default_nettype wire

// ---- verification/bss_boot_sequencer_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module bss_boot_sequencer_chk #(
  parameter integer SETTLE_CYC = 8,
  parameter integer PROBE_CYC = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Inputs
  input wire logic cold_power_up,
  input wire logic nwords_load,
  input wire logic [14:0] nwords_wdata,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  // Memory and RAM ports
  input wire logic mem_rd_q,
  input wire logic ram_wr_q,
  input wire logic [31:0] ram_wdata_q,
  // Power
  input wire logic dcdc_en_q,
  input wire logic ref_en_q,
  input wire logic core_ldo_en_q,
  input wire logic mem_ldo_en_q,
  input wire logic fast_crystal_oscillator_en_q,
  // Status
  input wire logic cold_start_q,
  input wire logic [3:0] state_q,
  input wire logic [14:0] mirror_word_count_q,
  input wire logic address_zero_remap_q,
  input wire logic soft_reset_q,
  // Host search
  input wire logic probe_active,
  input wire logic [3:0] probe_step,
  input wire logic [1:0] probe_if_kind,
  input wire logic [2:0] probe_clk_pin,
  input wire logic [2:0] probe_sel_pin,
  input wire logic [2:0] probe_din_pin,
  input wire logic [2:0] probe_dout_pin
);
  logic [31:0] rd_q;
  logic [1:0] kind_exp;
  logic [1:0] pair;
  logic [11:0] spi_pins;
  always @(posedge sys_clk) begin
    if (mem_rvalid) rd_q <= mem_rdata;
  end
  // Expected pin map
  always @* begin
    kind_exp = probe_step < 4'h2 ? 2'h0 : probe_step < 4'h6 ? 2'h1 :
      probe_step == 4'h6 ? 2'h2 : 2'h3;
    pair = probe_step < 4'h6 ? 2'(probe_step - 4'h2) : 2'(probe_step - 4'h7);
    spi_pins = probe_step == 4'h1 ? 12'h053 : 12'h0f5;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_rd_pulse; mem_rd_q |=> !mem_rd_q; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_wr_pulse; ram_wr_q |=> !ram_wr_q; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_wr_data; ram_wr_q |-> ram_wdata_q == rd_q; endproperty
  a_wr_data: assert property (p_wr_data) else $error("copied word differs");
  property p_nwords; nwords_load |=> mirror_word_count_q == $past(nwords_wdata); endproperty
  a_nwords: assert property (p_nwords) else $error("word count not loaded");
  property p_xtal_order; $rose(fast_crystal_oscillator_en_q) |->
    dcdc_en_q || (ref_en_q && core_ldo_en_q && mem_ldo_en_q); endproperty
  a_xtal_order: assert property (p_xtal_order) else $error("crystal before supply");
  property p_stage_order; ram_wr_q || probe_active |-> fast_crystal_oscillator_en_q; endproperty
  a_stage_order: assert property (p_stage_order) else $error("stage out of order");
  property p_reset_pulse; soft_reset_q |=> !soft_reset_q; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("soft reset too long");
  property p_remap_first; soft_reset_q |-> address_zero_remap_q; endproperty
  a_remap_first: assert property (p_remap_first) else $error("reset before remap");
  property p_cold_flag; cold_power_up && state_q == 4'h0 |-> ##[1:8] cold_start_q; endproperty
  a_cold_flag: assert property (p_cold_flag) else $error("cold start flag not set");
  property p_step_max; probe_active |-> probe_step <= 4'ha; endproperty
  a_step_max: assert property (p_step_max) else $error("probe step past last");
  property p_kind; probe_active |-> probe_if_kind == kind_exp; endproperty
  a_kind: assert property (p_kind) else $error("probe interface kind");
  property p_spi_pins; probe_active && !kind_exp[0] |->
    {probe_clk_pin, probe_sel_pin, probe_din_pin, probe_dout_pin} == spi_pins; endproperty
  a_spi_pins: assert property (p_spi_pins) else $error("serial master/slave pins");
  property p_pair_pins; probe_active && kind_exp[0] |-> (kind_exp[1] ?
    probe_clk_pin == {pair, 1'b0} : probe_din_pin == {pair, 1'b1}); endproperty
  a_pair_pins: assert property (p_pair_pins) else $error("pin pair mismatch");
endmodule // bss_boot_sequencer_chk
bind bss_boot_sequencer bss_boot_sequencer_chk
  #(.SETTLE_CYC(SETTLE_CYC), .PROBE_CYC(PROBE_CYC)) u_chk (.*);
`default_nettype wire

// ---- verification/bss_otp_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Memory model; slow adds four wait cycles
module bss_otp_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Test control
  input wire logic slow,
  // Read port
  input wire logic mem_rd_q,
  input wire logic [14:0] mem_addr_q,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:8191];
  logic [14:0] adr_q;
  logic [2:0] wait_q;
  logic busy_q = 1'b0;
  initial mem_rvalid = 1'b0;
  initial mem_rdata = 32'h0;
  always @(posedge sys_clk) begin
    mem_rvalid <= 1'b0;
    // Toggling data exposes late sampling
    mem_rdata <= ~mem_rdata;
    if (srst) begin
      busy_q <= 1'b0;
    end else if (mem_rd_q && !busy_q) begin
      busy_q <= 1'b1;
      adr_q <= mem_addr_q;
      wait_q <= slow ? 3'h4 : 3'h0;
    end else if (busy_q && wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      mem_rvalid <= 1'b1;
      mem_rdata <= mem[adr_q[14:2]];
    end
  end
endmodule // bss_otp_model
`default_nettype wire
